// file: pdcm_pkg.sv
// Constants for the dynamic clock configuration multiplexer
package pdcm_pkg;

    // Configuration word layout
    localparam int CFG_WIDTH     = 81;
    localparam int SRC_SEL_LSB   = 29;
    localparam int SRC_SEL_W     = 3;
    localparam int SEC2_DIV_LSB  = 24;
    localparam int SEC1_DIV_LSB  = 19;
    localparam int PRI_DIV_LSB   = 14;
    localparam int OUT_DIV_W     = 5;
    localparam int FB_DIV_LSB    = 7;
    localparam int IN_DIV_LSB    = 0;
    localparam int PLL_DIV_W     = 7;

    // Fixed nonvolatile configuration, plain default
    localparam logic [CFG_WIDTH-1:0] NV_DEFAULT = 81'h0;

    // Output source select codes
    localparam logic [2:0] SEL_BYPASS    = 3'h0;
    localparam logic [2:0] SEL_NA1       = 3'h1;
    localparam logic [2:0] SEL_DELAY     = 3'h2;
    localparam logic [2:0] SEL_NA3       = 3'h3;
    localparam logic [2:0] SEL_VCO_0     = 3'h4;
    localparam logic [2:0] SEL_VCO_270   = 3'h5;
    localparam logic [2:0] SEL_VCO_180   = 3'h6;
    localparam logic [2:0] SEL_VCO_90    = 3'h7;

    // Phase one-hot bit positions
    localparam int PH_0   = 0;
    localparam int PH_90  = 1;
    localparam int PH_180 = 2;
    localparam int PH_270 = 3;

    // Register bus
    localparam int ADDR_W = 8;
    localparam logic [ADDR_W-1:0] OFF_CTRL   = 8'h00;
    localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h04;
    localparam logic [ADDR_W-1:0] OFF_ACT0   = 8'h08;
    localparam logic [ADDR_W-1:0] OFF_ACT1   = 8'h0c;
    localparam logic [ADDR_W-1:0] OFF_ACT2   = 8'h10;
    localparam logic [ADDR_W-1:0] OFF_SHF0   = 8'h14;
    localparam logic [ADDR_W-1:0] OFF_SHF1   = 8'h18;
    localparam logic [ADDR_W-1:0] OFF_SHF2   = 8'h1c;

    // Control and status fields
    localparam int CTRL_FREEZE_BIT = 0;
    localparam logic [31:0] CTRL_RESET = 32'h0;
    localparam int STAT_MODE_BIT  = 0;
    localparam int STAT_FREEZE_BIT = 1;
    localparam int STAT_CNT_LSB   = 8;
    localparam int UPD_CNT_W      = 8;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Synchroniser lanes
    localparam int SYN_IN    = 0;
    localparam int SYN_CLK   = 1;
    localparam int SYN_SHIFT = 2;
    localparam int SYN_UPD   = 3;
    localparam int SYN_MODE  = 4;
    localparam int SYN_W     = 5;

endpackage : pdcm_pkg

// file: pdcm_sync.sv
// Two-flop synchronisers, one per lane
`timescale 1ns/1ps
module pdcm_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input  wire logic         aclk,
    input  wire logic         aresetn,
    // Lanes
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);
    logic [W-1:0] meta_reg;

    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_lane
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    meta_reg[i] <= 1'b0;
                    sync_out[i] <= 1'b0;
                end else begin
                    meta_reg[i] <= async_in[i];
                    sync_out[i] <= meta_reg[i];
                end
            end
        end
    endgenerate
endmodule : pdcm_sync

// file: pdcm_src_decode.sv
// Decode of an output source select code into routing flags
`timescale 1ns/1ps
module pdcm_src_decode
    import pdcm_pkg::*;
(
    // Select code
    input  wire logic [2:0] sel,
    // Routing flags
    output logic            bypass,
    output logic            delay_line,
    output logic [3:0]      vco_phase,
    output logic            unusable
);
    assign bypass     = (sel == SEL_BYPASS);
    assign delay_line = (sel == SEL_DELAY);
    assign unusable   = (sel == SEL_NA1) || (sel == SEL_NA3);
    assign vco_phase[PH_0]   = (sel == SEL_VCO_0);
    assign vco_phase[PH_90]  = (sel == SEL_VCO_90);
    assign vco_phase[PH_180] = (sel == SEL_VCO_180);
    assign vco_phase[PH_270] = (sel == SEL_VCO_270);
endmodule : pdcm_src_decode

// file: pdcm_top.sv
// Dynamic configuration path and decode for the clock conditioner
//
// Operation
// - Configuration can change at run time by a shift followed by an update.
// - Mode high selects the dynamic bits, mode low the fixed nonvolatile bits.
// - The configuration word holds 81 bits.
// - Bits 31..29 are the primary output source select.
// - Bits 28..24 set the second secondary divider, ratio field plus one.
// - Bits 23..19 set the first secondary divider, ratio field plus one.
// - Bits 18..14 set the primary output divider, ratio field plus one.
// - Bits 13..7 set the feedback divider, ratio field plus one.
// - Bits 6..0 set the input divider, ratio field plus one.
// - Select zero bypasses PLL and six-input mux.
// - Select two routes the feedback delay line; one and three are unusable.
// - Selects four to seven pick VCO phase 0, 270, 180 and 90 degrees.
//
// Our own choices: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/1ps
module pdcm_top
    import pdcm_pkg::*;
#(
    parameter logic [CFG_WIDTH-1:0] NV_CONFIG = NV_DEFAULT
) (
    // Clock and reset
    input  wire logic                  aclk,
    input  wire logic                  aresetn,
    // Serial configuration port
    input  wire logic                  cfg_serial_in,
    input  wire logic                  cfg_serial_clock,
    input  wire logic                  cfg_shift_enable,
    input  wire logic                  cfg_update_strobe,
    input  wire logic                  cfg_mode_dynamic,
    output logic                       cfg_serial_out,
    // Decoded configuration
    output logic [SRC_SEL_W-1:0]       primary_source_select,
    output logic [OUT_DIV_W-1:0]       primary_output_divider,
    output logic [OUT_DIV_W-1:0]       secondary1_output_divider,
    output logic [OUT_DIV_W-1:0]       secondary2_output_divider,
    output logic [PLL_DIV_W-1:0]       feedback_divider,
    output logic [PLL_DIV_W-1:0]       input_divider,
    output logic [OUT_DIV_W:0]         primary_div_ratio,
    output logic [OUT_DIV_W:0]         secondary1_div_ratio,
    output logic [OUT_DIV_W:0]         secondary2_div_ratio,
    output logic [PLL_DIV_W:0]         feedback_ratio,
    output logic [PLL_DIV_W:0]         input_ratio,
    output logic                       primary_bypass,
    output logic                       primary_delay_line,
    output logic [3:0]                 primary_vco_phase,
    output logic                       primary_sel_unusable,
    // AXI4-Lite write address
    input  wire logic [ADDR_W-1:0]     s_axi_awaddr,
    input  wire logic                  s_axi_awvalid,
    output logic                       s_axi_awready,
    // AXI4-Lite write data
    input  wire logic [31:0]           s_axi_wdata,
    input  wire logic [3:0]            s_axi_wstrb,
    input  wire logic                  s_axi_wvalid,
    output logic                       s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0]                 s_axi_bresp,
    output logic                       s_axi_bvalid,
    input  wire logic                  s_axi_bready,
    // AXI4-Lite read address
    input  wire logic [ADDR_W-1:0]     s_axi_araddr,
    input  wire logic                  s_axi_arvalid,
    output logic                       s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0]                s_axi_rdata,
    output logic [1:0]                 s_axi_rresp,
    output logic                       s_axi_rvalid,
    input  wire logic                  s_axi_rready
);
    // Pin synchronisation
    logic [SYN_W-1:0]     pins_async;
    logic [SYN_W-1:0]     pins_sync;
    logic                 sclk_prev_reg;
    logic                 upd_prev_reg;

    // Configuration storage
    logic [CFG_WIDTH-1:0] shift_reg;
    logic [CFG_WIDTH-1:0] dyn_cfg_reg;
    logic [CFG_WIDTH-1:0] active_cfg;
    logic [UPD_CNT_W-1:0] upd_cnt_reg;
    logic [31:0]          ctrl_reg;

    logic                 shift_edge;
    logic                 update_edge;
    logic                 mode_dyn;
    logic                 freeze;

    // Decoder outputs
    logic                 dec_bypass;
    logic                 dec_delay;
    logic [3:0]           dec_phase;
    logic                 dec_unusable;

    // Bus state
    logic                 aw_hold_reg;
    logic                 w_hold_reg;
    logic [ADDR_W-1:0]    awaddr_reg;
    logic [31:0]          wdata_reg;
    logic [3:0]           wstrb_reg;
    logic                 aw_take;
    logic                 w_take;
    logic                 ar_take;
    logic                 wr_fire;
    logic                 aw_hold_next;
    logic                 w_hold_next;
    logic                 bvalid_next;
    logic                 rvalid_next;
    logic                 wr_ctrl;
    logic                 wr_known;
    logic [31:0]          rd_mux;
    logic                 rd_known;
    logic [31:0]          status_word;
    logic [31:0]          ctrl_next;

    // Serial clock is oversampled, not used as a clock
    assign pins_async[SYN_IN]    = cfg_serial_in;
    assign pins_async[SYN_CLK]   = cfg_serial_clock;
    assign pins_async[SYN_SHIFT] = cfg_shift_enable;
    assign pins_async[SYN_UPD]   = cfg_update_strobe;
    assign pins_async[SYN_MODE]  = cfg_mode_dynamic;

    pdcm_sync #(
        .W        (SYN_W)
    ) u_sync (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .async_in (pins_async),
        .sync_out (pins_sync)
    );

    // Serial clock must stay below a quarter of aclk
    assign shift_edge  = pins_sync[SYN_CLK] && !sclk_prev_reg
                         && pins_sync[SYN_SHIFT];
    assign freeze      = ctrl_reg[CTRL_FREEZE_BIT];
    assign update_edge = pins_sync[SYN_UPD] && !upd_prev_reg
                         && !freeze;
    assign mode_dyn    = pins_sync[SYN_MODE];
    assign active_cfg  = mode_dyn ? dyn_cfg_reg : NV_CONFIG;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sclk_prev_reg <= 1'b0;
            upd_prev_reg  <= 1'b0;
        end else begin
            sclk_prev_reg <= pins_sync[SYN_CLK];
            upd_prev_reg  <= pins_sync[SYN_UPD];
        end
    end

    // Shift in at bit 0, out from the top bit
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            shift_reg <= '0;
        end else if (shift_edge) begin
            shift_reg <= {shift_reg[CFG_WIDTH-2:0],
                          pins_sync[SYN_IN]};
        end
    end

    // Dynamic word comes up as the plain default NV_DEFAULT, not NV_CONFIG
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            dyn_cfg_reg <= NV_DEFAULT;
            upd_cnt_reg <= '0;
        end else if (update_edge) begin
            dyn_cfg_reg <= shift_reg;
            upd_cnt_reg <= upd_cnt_reg + 8'h01;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cfg_serial_out <= 1'b0;
        end else begin
            cfg_serial_out <= shift_reg[CFG_WIDTH-1];
        end
    end

    pdcm_src_decode u_dec (
        .sel        (active_cfg[SRC_SEL_LSB +: SRC_SEL_W]),
        .bypass     (dec_bypass),
        .delay_line (dec_delay),
        .vco_phase  (dec_phase),
        .unusable   (dec_unusable)
    );

    // Registered field outputs
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            primary_source_select     <= '0;
            primary_output_divider    <= '0;
            secondary1_output_divider <= '0;
            secondary2_output_divider <= '0;
            feedback_divider          <= '0;
            input_divider             <= '0;
            primary_div_ratio         <= 6'h01;
            secondary1_div_ratio      <= 6'h01;
            secondary2_div_ratio      <= 6'h01;
            feedback_ratio            <= 8'h01;
            input_ratio               <= 8'h01;
            primary_bypass            <= 1'b1;
            primary_delay_line        <= 1'b0;
            primary_vco_phase         <= 4'h0;
            primary_sel_unusable      <= 1'b0;
        end else begin
            primary_source_select <=
                active_cfg[SRC_SEL_LSB +: SRC_SEL_W];
            secondary2_output_divider <=
                active_cfg[SEC2_DIV_LSB +: OUT_DIV_W];
            secondary1_output_divider <=
                active_cfg[SEC1_DIV_LSB +: OUT_DIV_W];
            primary_output_divider <=
                active_cfg[PRI_DIV_LSB +: OUT_DIV_W];
            feedback_divider <=
                active_cfg[FB_DIV_LSB +: PLL_DIV_W];
            input_divider <=
                active_cfg[IN_DIV_LSB +: PLL_DIV_W];
            secondary2_div_ratio <= {1'b0,
                active_cfg[SEC2_DIV_LSB +: OUT_DIV_W]} + 6'h01;
            secondary1_div_ratio <= {1'b0,
                active_cfg[SEC1_DIV_LSB +: OUT_DIV_W]} + 6'h01;
            primary_div_ratio <= {1'b0,
                active_cfg[PRI_DIV_LSB +: OUT_DIV_W]} + 6'h01;
            feedback_ratio <= {1'b0,
                active_cfg[FB_DIV_LSB +: PLL_DIV_W]} + 8'h01;
            input_ratio <= {1'b0,
                active_cfg[IN_DIV_LSB +: PLL_DIV_W]} + 8'h01;
            primary_bypass       <= dec_bypass;
            primary_delay_line   <= dec_delay;
            primary_sel_unusable <= dec_unusable;
            primary_vco_phase    <= dec_phase;
        end
    end

    // Write channel: address and data taken in either order
    assign aw_take      = s_axi_awvalid && s_axi_awready;
    assign w_take       = s_axi_wvalid && s_axi_wready;
    assign wr_fire      = aw_hold_reg && w_hold_reg;
    assign aw_hold_next = !wr_fire && (aw_hold_reg || aw_take);
    assign w_hold_next  = !wr_fire && (w_hold_reg || w_take);
    assign bvalid_next  = wr_fire || (s_axi_bvalid && !s_axi_bready);
    assign wr_ctrl      = wr_fire && (awaddr_reg[ADDR_W-1:2]
                          == OFF_CTRL[ADDR_W-1:2]);
    // Read-only words accept writes and ignore them
    assign wr_known     = (awaddr_reg[ADDR_W-1:2] <= OFF_SHF2[ADDR_W-1:2]);
    assign ctrl_next    = {ctrl_reg[31:8],
                           s_axi_wstrb_lane0(wstrb_reg, wdata_reg,
                                             ctrl_reg)};

    function automatic logic [7:0] s_axi_wstrb_lane0(
        input logic [3:0]  strb,
        input logic [31:0] data,
        input logic [31:0] old
    );
        logic [7:0] lane;
        lane = strb[0] ? {7'h00, data[CTRL_FREEZE_BIT]}
                       : old[7:0];
        return lane;
    endfunction : s_axi_wstrb_lane0

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold_reg   <= 1'b0;
            w_hold_reg    <= 1'b0;
            awaddr_reg    <= '0;
            wdata_reg     <= '0;
            wstrb_reg     <= '0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= RESP_OKAY;
            ctrl_reg      <= CTRL_RESET;
        end else begin
            aw_hold_reg   <= aw_hold_next;
            w_hold_reg    <= w_hold_next;
            s_axi_awready <= !aw_hold_next && !bvalid_next;
            s_axi_wready  <= !w_hold_next && !bvalid_next;
            s_axi_bvalid  <= bvalid_next;
            if (aw_take) begin
                awaddr_reg <= s_axi_awaddr;
            end
            if (w_take) begin
                wdata_reg <= s_axi_wdata;
                wstrb_reg <= s_axi_wstrb;
            end
            if (wr_fire) begin
                s_axi_bresp <= wr_known ? RESP_OKAY : RESP_SLVERR;
            end
            if (wr_ctrl) begin
                ctrl_reg <= ctrl_next;
            end
        end
    end

    // Read channel
    assign ar_take     = s_axi_arvalid && s_axi_arready;
    assign rvalid_next = ar_take || (s_axi_rvalid && !s_axi_rready);
    assign status_word = {16'h0000, upd_cnt_reg, 6'h00,
                          freeze, mode_dyn};
    assign rd_known    = (s_axi_araddr[ADDR_W-1:2]
                          <= OFF_SHF2[ADDR_W-1:2]);

    always_comb begin
        unique case (s_axi_araddr[ADDR_W-1:2])
            OFF_CTRL[ADDR_W-1:2]:   rd_mux = ctrl_reg;
            OFF_STATUS[ADDR_W-1:2]: rd_mux = status_word;
            OFF_ACT0[ADDR_W-1:2]:   rd_mux = active_cfg[31:0];
            OFF_ACT1[ADDR_W-1:2]:   rd_mux = active_cfg[63:32];
            OFF_ACT2[ADDR_W-1:2]:   rd_mux = {15'h0000,
                                              active_cfg[80:64]};
            OFF_SHF0[ADDR_W-1:2]:   rd_mux = shift_reg[31:0];
            OFF_SHF1[ADDR_W-1:2]:   rd_mux = shift_reg[63:32];
            OFF_SHF2[ADDR_W-1:2]:   rd_mux = {15'h0000,
                                              shift_reg[80:64]};
            default:                rd_mux = 32'h0;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= '0;
            s_axi_rresp   <= RESP_OKAY;
        end else begin
            s_axi_arready <= !rvalid_next;
            s_axi_rvalid  <= rvalid_next;
            if (ar_take) begin
                s_axi_rdata <= rd_mux;
                s_axi_rresp <= rd_known ? RESP_OKAY : RESP_SLVERR;
            end
        end
    end

    // Checks
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    AST_MODE_SELECT: assert property (
        $past(aresetn) |-> primary_source_select == ($past(mode_dyn)
            ? $past(dyn_cfg_reg[31:29]) : NV_CONFIG[31:29]))
        else $error("source select not from chosen configuration");

    AST_SHIFT_ONE_BIT: assert property (
        shift_edge |=> shift_reg == {$past(shift_reg[79:0]),
                                     $past(pins_sync[SYN_IN])})
        else $error("shift did not move one bit");

    AST_HOLD_NO_SHIFT: assert property (
        !shift_edge |=> $stable(shift_reg))
        else $error("shift register moved without edge");

    AST_UPDATE_LOAD: assert property (
        update_edge |=> dyn_cfg_reg == $past(shift_reg))
        else $error("update did not load shifted word");

    AST_FREEZE_BLOCKS: assert property (
        freeze |=> $stable(dyn_cfg_reg))
        else $error("dynamic word changed while frozen");

    AST_DIV_PLUS_ONE: assert property (
        primary_div_ratio == {1'b0, primary_output_divider} + 6'h01
        && secondary1_div_ratio
           == {1'b0, secondary1_output_divider} + 6'h01)
        else $error("output divider ratio not field plus one");

    AST_PLL_PLUS_ONE: assert property (
        feedback_ratio == {1'b0, feedback_divider} + 8'h01
        && input_ratio == {1'b0, input_divider} + 8'h01)
        else $error("pll divider ratio not field plus one");

    AST_BYPASS_ZERO: assert property (
        primary_bypass == (primary_source_select == 3'h0))
        else $error("bypass flag does not match select zero");

    AST_DELAY_TWO: assert property (
        primary_delay_line == (primary_source_select == 3'h2))
        else $error("delay line flag does not match select two");

    AST_PHASE_MAP: assert property (
        primary_source_select == 3'h5 |-> primary_vco_phase == 4'h8)
        else $error("select five is not 270 degree phase");

    AST_SERIAL_OUT: assert property (
        cfg_serial_out == $past(shift_reg[80]))
        else $error("serial out not top shift bit");

    AST_BVALID_HOLD: assert property (
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write response dropped before ready");

endmodule : pdcm_top

// file: pdcm_cfg_driver.sv
// Core logic model driving the serial configuration port
`timescale 1ns/1ps
module pdcm_cfg_driver
    import pdcm_pkg::*;
(
    // Clock
    input  wire logic aclk,
    // Serial configuration port
    output logic      cfg_serial_in,
    output logic      cfg_serial_clock,
    output logic      cfg_shift_enable,
    output logic      cfg_update_strobe,
    output logic      cfg_mode_dynamic
);
    initial begin
        {cfg_serial_in, cfg_serial_clock, cfg_shift_enable} = 3'h0;
        {cfg_update_strobe, cfg_mode_dynamic} = 2'h0;
    end
    task automatic hold(input int n);
        repeat (n) @(posedge aclk);
    endtask : hold
    // Four cycles a half, so the oversampler sees every edge
    task automatic load(input logic [CFG_WIDTH-1:0] w);
        cfg_shift_enable <= 1'b1;
        for (int i = CFG_WIDTH - 1; i >= 0; i--) begin
            cfg_serial_in <= w[i];
            hold(4);
            cfg_serial_clock <= 1'b1;
            hold(4);
            cfg_serial_clock <= 1'b0;
        end
        hold(4);
        cfg_shift_enable <= 1'b0;
        // Released line toggles so no stale bit looks valid
        cfg_serial_in <= ~cfg_serial_in;
        hold(4);
        cfg_update_strobe <= 1'b1;
        hold(4);
        cfg_update_strobe <= 1'b0;
        hold(4);
    endtask : load
    task automatic set_mode(input logic m);
        cfg_mode_dynamic <= m;
        hold(8);
    endtask : set_mode
endmodule : pdcm_cfg_driver

// file: pll_dynamic_config_mux_tb.sv
// Self-checking bench for the dynamic clock configuration path
`timescale 1ns/1ps
module pll_dynamic_config_mux_tb;
    import pdcm_pkg::*;
    logic aclk, aresetn, cfg_serial_in, cfg_serial_clock, cfg_shift_enable;
    logic cfg_update_strobe, cfg_mode_dynamic, cfg_serial_out;
    logic [2:0] primary_source_select;
    logic [4:0] primary_output_divider, secondary1_output_divider;
    logic [4:0] secondary2_output_divider;
    logic [6:0] feedback_divider, input_divider;
    logic [5:0] primary_div_ratio, secondary1_div_ratio;
    logic [5:0] secondary2_div_ratio;
    logic [7:0] feedback_ratio, input_ratio, s_axi_awaddr, s_axi_araddr;
    logic primary_bypass, primary_delay_line, primary_sel_unusable;
    logic [3:0] primary_vco_phase, s_axi_wstrb;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic s_axi_rvalid, s_axi_rready;
    int error_cnt = 0, checks = 0, cycles = 0;
    logic [3:0] ph [8] = '{4'h0, 4'h0, 4'h0, 4'h0, 4'h1, 4'h8, 4'h4, 4'h2};
    pdcm_top i_dut (
        .aclk, .aresetn, .cfg_serial_in, .cfg_serial_clock, .cfg_shift_enable,
        .cfg_update_strobe, .cfg_mode_dynamic, .cfg_serial_out,
        .primary_source_select, .primary_output_divider,
        .secondary1_output_divider, .secondary2_output_divider,
        .feedback_divider, .input_divider, .primary_div_ratio,
        .secondary1_div_ratio, .secondary2_div_ratio, .feedback_ratio,
        .input_ratio, .primary_bypass, .primary_delay_line,
        .primary_vco_phase, .primary_sel_unusable, .s_axi_awaddr,
        .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready
    );
    pdcm_cfg_driver i_drv (
        .aclk, .cfg_serial_in, .cfg_serial_clock, .cfg_shift_enable,
        .cfg_update_strobe, .cfg_mode_dynamic
    );
    initial begin
        aclk = 1'b0;
        forever #50 aclk = ~aclk;
    end
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : print_verdict
    // Nine frames of about 700 cycles each, with ample margin
    always @(posedge aclk) begin
        cycles++;
        if (cycles == 30000) begin
            error_cnt++;
            print_verdict();
        end
    end
    task automatic chk(input string nm, input logic [80:0] seen, exp);
        checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("BAD %s expected %0h seen %0h", nm, exp, seen);
        end
    endtask : chk
    task automatic axw(input logic [7:0] a, input logic [31:0] d,
                       output logic [1:0] r);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        forever begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid && s_axi_bready) begin
                r = s_axi_bresp;
                s_axi_bready <= 1'b0;
                break;
            end
        end
    endtask : axw
    task automatic axr(input logic [7:0] a, output logic [31:0] d,
                       output logic [1:0] r);
        @(posedge aclk);
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'h3;
        forever begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid && s_axi_rready) begin
                d = s_axi_rdata;
                r = s_axi_rresp;
                s_axi_rready <= 1'b0;
                break;
            end
        end
    endtask : axr
    initial begin
        logic [80:0] w;
        logic [31:0] d;
        logic [1:0] r;
        logic [2:0] s;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
        {s_axi_arvalid, s_axi_rready, aresetn} = 3'h0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
        s_axi_wstrb = 4'hf;
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        i_drv.hold(4);
        chk("bypass", primary_bypass, 1'b1);
        chk("in_ratio", input_ratio, 8'h01);
        for (int k = 0; k < 8; k++) begin
            s = 3'(k);
            w = {49'h1_5a5a_c3c3_0ff0, s, 5'h1f ^ {2'h0, s}, {s, 2'h1},
                 {2'h0, s}, 7'h7f ^ {4'h0, s}, {s, 4'h0}};
            i_drv.load(w);
            if (k == 0) i_drv.set_mode(1'b1);
            else i_drv.hold(8);
            chk("sel", primary_source_select, s);
            chk("sec2_div", secondary2_output_divider, w[28:24]);
            chk("sec1_div", secondary1_output_divider, w[23:19]);
            chk("pri_div", primary_output_divider, w[18:14]);
            chk("fb_div", feedback_divider, w[13:7]);
            chk("in_div", input_divider, w[6:0]);
            chk("sec2_ratio", secondary2_div_ratio, w[28:24] + 6'h01);
            chk("sec1_ratio", secondary1_div_ratio, w[23:19] + 6'h01);
            chk("pri_ratio", primary_div_ratio, w[18:14] + 6'h01);
            chk("fb_ratio", feedback_ratio, w[13:7] + 8'h01);
            chk("in_ratio", input_ratio, w[6:0] + 8'h01);
            chk("bypass", primary_bypass, s == SEL_BYPASS);
            chk("delay", primary_delay_line, s == SEL_DELAY);
            chk("unusable", primary_sel_unusable,
                s == SEL_NA1 || s == SEL_NA3);
            chk("vco", primary_vco_phase, ph[k]);
            chk("sout", cfg_serial_out, w[80]);
            axr(OFF_ACT2, d, r);
            chk("act2", d, {15'h0, w[80:64]});
            chk("act2_resp", r, RESP_OKAY);
            axr(OFF_SHF0, d, r);
            chk("shf0", d, w[31:0]);
            $display("test select %0d done", k);
        end
        axr(OFF_STATUS, d, r);
        chk("upd_cnt", d[15:8], 8'h08);
        chk("mode", d[0], 1'b1);
        axw(OFF_CTRL, 32'h1, r);
        chk("ctrl_resp", r, RESP_OKAY);
        axr(OFF_CTRL, d, r);
        chk("ctrl", d, 32'h1);
        i_drv.load(~w);
        chk("frozen", primary_source_select, w[31:29]);
        axr(OFF_SHF0, d, r);
        chk("shf_frozen", d, 32'(~w[31:0]));
        axw(OFF_CTRL, 32'h0, r);
        $display("test freeze done");
        i_drv.set_mode(1'b0);
        chk("nv_sel", primary_source_select, 3'h0);
        chk("nv_fb", feedback_ratio, 8'h01);
        axw(8'h20, 32'h1, r);
        chk("wr_err", r, RESP_SLVERR);
        axr(8'h20, d, r);
        chk("rd_err", r, RESP_SLVERR);
        chk("rd_zero", d, 32'h0);
        $display("test unmapped done");
        print_verdict();
    end
endmodule : pll_dynamic_config_mux_tb
